// ---- hdl/fsp_pkg.sv ----
// Package: constants for the flash status poller
package fsp_pkg;
    // Host register offsets (byte addresses)
    localparam logic [3:0] FSP_REG_CTRL = 4'h0;
    localparam logic [3:0] FSP_REG_ADDR = 4'h4;
    localparam logic [3:0] FSP_REG_DATA = 4'h8;
    localparam logic [3:0] FSP_REG_STAT = 4'hc;
    // Control field positions
    localparam int FSP_CTRL_START = 0;
    localparam int FSP_CTRL_MODE = 1;
    localparam int FSP_CTRL_ABORT = 2;
    // Status field positions
    localparam int FSP_ST_BUSY = 0;
    localparam int FSP_ST_DONE = 1;
    localparam int FSP_ST_TIMEOUT = 2;
    localparam int FSP_ST_ABORT = 3;
    localparam int FSP_ST_SUSP = 4;
    localparam int FSP_ST_FAIL = 5;
    // Status bit positions on the flash data bus
    localparam int FSP_DQ_POLL = 7;
    localparam int FSP_DQ_TOG1 = 6;
    localparam int FSP_DQ_TMO = 5;
    localparam int FSP_DQ_TOG2 = 2;
    localparam int FSP_DQ_BABT = 1;
    // Widths
    localparam int FSP_AW = 26;
    localparam int FSP_DW = 16;
    // Timing of one flash read cycle
    localparam int FSP_CLK_MHZ = 125;
    localparam int FSP_T_ACC_NS = 110;
    localparam int FSP_T_HIGH_NS = 30;
    localparam int FSP_ACC_CYC = (FSP_T_ACC_NS * FSP_CLK_MHZ + 999) / 1000;
    localparam int FSP_HIGH_CYC = (FSP_T_HIGH_NS * FSP_CLK_MHZ + 999) / 1000;
    // Poll mode
    localparam logic FSP_MODE_TOGGLE = 1'b0;
    localparam logic FSP_MODE_POLL = 1'b1;
endpackage

// ---- hdl/fsp_read_cycle.sv ----
// Single asynchronous flash read cycle engine
`timescale 1ns/1ps
module fsp_read_cycle #(
    parameter int ACC_CYC = fsp_pkg::FSP_ACC_CYC,
    parameter int HIGH_CYC = fsp_pkg::FSP_HIGH_CYC,
    parameter int DW = fsp_pkg::FSP_DW
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic [DW-1:0] dq_sync_i,
    output logic oe_n_o,
    output logic done_o,
    output logic [DW-1:0] data_o
);
    import fsp_pkg::*;
    // ==========================================
    // Read cycle: strobe low, sample, strobe high
    typedef enum logic [1:0] {RC_IDLE, RC_LOW, RC_HIGH} fsp_rc_t;
    fsp_rc_t st_q;
    logic [7:0] cnt_q;
    wire cnt_end = (cnt_q == 8'h00);
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            st_q <= RC_IDLE;
            cnt_q <= 8'h00;
            oe_n_o <= 1'b1;
            done_o <= 1'b0;
            data_o <= '0;
        end else begin
            done_o <= 1'b0;
            case (st_q)
                RC_IDLE: begin
                    if (start_i) begin
                        st_q <= RC_LOW;
                        oe_n_o <= 1'b0;
                        cnt_q <= 8'(ACC_CYC + 2);
                    end
                end
                RC_LOW: begin
                    if (cnt_end) begin
                        data_o <= dq_sync_i;
                        oe_n_o <= 1'b1;
                        cnt_q <= 8'(HIGH_CYC);
                        st_q <= RC_HIGH;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                RC_HIGH: begin
                    if (cnt_end) begin
                        done_o <= 1'b1;
                        st_q <= RC_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: st_q <= RC_IDLE;
            endcase
        end
    end
endmodule

// ---- hdl/fsp_status_poller.sv ----
// Host-side poller of flash write operation status bits
`timescale 1ns/1ps
module fsp_status_poller #(
    parameter int AW = fsp_pkg::FSP_AW,
    parameter int DW = fsp_pkg::FSP_DW
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    output logic [AW-1:0] flash_addr_o,
    output logic flash_ce_n_o,
    output logic flash_oe_n_o,
    output logic flash_we_n_o,
    input wire logic [DW-1:0] flash_dq_i,
    output logic [DW-1:0] flash_dq_o,
    output logic flash_dq_oe_o,
    output logic busy_o
);
    import fsp_pkg::*;
    // ==========================================
    // Pin synchroniser
    logic [DW-1:0] dq_s1_q;
    logic [DW-1:0] dq_s2_q;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
        end else begin
            dq_s1_q <= flash_dq_i;
            dq_s2_q <= dq_s1_q;
        end
    end

    // ==========================================
    // Host registers
    logic mode_q;
    logic [AW-1:0] addr_q;
    logic [7:0] expect_q;
    logic busy_q;
    logic done_q;
    logic tmo_q;
    logic babt_q;
    logic susp_q;
    logic fail_q;
    logic [DW-1:0] last_q;
    wire wr_ctrl = reg_wr_i && (reg_addr_i == FSP_REG_CTRL);
    wire wr_addr = reg_wr_i && (reg_addr_i == FSP_REG_ADDR);
    wire wr_data = reg_wr_i && (reg_addr_i == FSP_REG_DATA);
    wire start_cmd = wr_ctrl && reg_wdata_i[FSP_CTRL_START] && !busy_q;
    wire abort_cmd = wr_ctrl && reg_wdata_i[FSP_CTRL_ABORT];
    wire [31:0] stat_word = {26'h0, fail_q, susp_q, babt_q, tmo_q, done_q, busy_q};
    wire [31:0] rd_mux = (reg_addr_i == FSP_REG_CTRL) ? {31'h0, mode_q} :
                         (reg_addr_i == FSP_REG_ADDR) ? 32'(addr_q) :
                         (reg_addr_i == FSP_REG_DATA) ? {8'h0, expect_q, last_q} :
                         (reg_addr_i == FSP_REG_STAT) ? stat_word : 32'h0;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= 32'h0;
            mode_q <= FSP_MODE_TOGGLE;
            addr_q <= '0;
            expect_q <= 8'h00;
        end else begin
            if (reg_rd_i) begin
                reg_rdata_o <= rd_mux;
            end
            if (wr_ctrl && !busy_q) begin
                mode_q <= reg_wdata_i[FSP_CTRL_MODE];
            end
            if (wr_addr && !busy_q) begin
                addr_q <= AW'(reg_wdata_i);
            end
            if (wr_data && !busy_q) begin
                expect_q <= reg_wdata_i[7:0];
            end
        end
    end

    // ==========================================
    // Read cycle engine
    logic rd_go_q;
    logic rd_done;
    logic rd_oe_n;
    logic [DW-1:0] rd_data;
    fsp_read_cycle #(.DW(DW)) u_rc (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .start_i(rd_go_q),
        .dq_sync_i(dq_s2_q),
        .oe_n_o(rd_oe_n),
        .done_o(rd_done),
        .data_o(rd_data)
    );

    // ==========================================
    // Status decode
    function automatic logic tog_diff(input logic [DW-1:0] a, input logic [DW-1:0] b, input int pos);
        tog_diff = a[pos] ^ b[pos];
    endfunction
    wire t1_tog = tog_diff(rd_data, last_q, FSP_DQ_TOG1);
    wire t2_tog = tog_diff(rd_data, last_q, FSP_DQ_TOG2);
    wire poll_ok = rd_data[FSP_DQ_POLL] == expect_q[FSP_DQ_POLL];
    // Fault bits come from the older read of a toggling pair, which is always status
    wire tmo_bit = last_q[FSP_DQ_TMO];
    wire babt_bit = last_q[FSP_DQ_BABT];

    // ==========================================
    // Polling sequencer
    typedef enum logic [2:0] {PS_IDLE, PS_READ, PS_WAIT, PS_EVAL, PS_RECHK, PS_CONF} fsp_ps_t;
    fsp_ps_t ps_q;
    logic first_q;
    logic tmo_seen_q;
    logic tog_prev_q;
    logic fin_q;
    logic abort_q;
    wire settled = (mode_q == FSP_MODE_POLL) ? poll_ok : !t1_tog;
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            ps_q <= PS_IDLE;
            rd_go_q <= 1'b0;
            first_q <= 1'b0;
            tmo_seen_q <= 1'b0;
            tog_prev_q <= 1'b0;
            fin_q <= 1'b0;
            abort_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
            tmo_q <= 1'b0;
            babt_q <= 1'b0;
            susp_q <= 1'b0;
            fail_q <= 1'b0;
            last_q <= '0;
        end else begin
            rd_go_q <= 1'b0;
            if (abort_cmd && busy_q) begin
                abort_q <= 1'b1;
            end
            case (ps_q)
                PS_IDLE: begin
                    if (start_cmd) begin
                        busy_q <= 1'b1;
                        done_q <= 1'b0;
                        tmo_q <= 1'b0;
                        babt_q <= 1'b0;
                        susp_q <= 1'b0;
                        fail_q <= 1'b0;
                        first_q <= 1'b1;
                        tmo_seen_q <= 1'b0;
                        tog_prev_q <= 1'b0;
                        fin_q <= 1'b0;
                        abort_q <= 1'b0;
                        ps_q <= PS_READ;
                    end
                end
                PS_READ: begin
                    rd_go_q <= 1'b1;
                    ps_q <= PS_WAIT;
                end
                PS_WAIT: begin
                    if (rd_done) begin
                        ps_q <= PS_EVAL;
                    end
                end
                PS_EVAL: begin
                    last_q <= rd_data;
                    first_q <= 1'b0;
                    if (first_q) begin
                        ps_q <= PS_READ;
                    end else if (abort_q) begin
                        ps_q <= PS_CONF;
                    end else if (settled && mode_q == FSP_MODE_POLL && !fin_q) begin
                        fin_q <= 1'b1;
                        ps_q <= PS_READ;
                    end else if (settled) begin
                        if (!t1_tog && t2_tog && mode_q == FSP_MODE_TOGGLE) begin
                            susp_q <= 1'b1;
                        end
                        fail_q <= 1'b0;
                        ps_q <= PS_CONF;
                        done_q <= 1'b1;
                    end else if (mode_q == FSP_MODE_TOGGLE && !tog_prev_q) begin
                        tog_prev_q <= 1'b1;
                        ps_q <= PS_READ;
                    end else if (babt_bit) begin
                        babt_q <= 1'b1;
                        fail_q <= 1'b1;
                        ps_q <= PS_CONF;
                    end else if (tmo_seen_q) begin
                        tmo_q <= 1'b1;
                        fail_q <= 1'b1;
                        ps_q <= PS_CONF;
                    end else if (tmo_bit) begin
                        tmo_seen_q <= 1'b1;
                        ps_q <= PS_RECHK;
                    end else begin
                        ps_q <= PS_READ;
                    end
                end
                PS_RECHK: begin
                    rd_go_q <= 1'b1;
                    ps_q <= PS_WAIT;
                end
                PS_CONF: begin
                    busy_q <= 1'b0;
                    tmo_seen_q <= 1'b0;
                    tog_prev_q <= 1'b0;
                    fin_q <= 1'b0;
                    ps_q <= PS_IDLE;
                end
                default: ps_q <= PS_IDLE;
            endcase
        end
    end

    // ==========================================
    // Flash pins: read only, write strobe idle
    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            flash_addr_o <= '0;
            flash_ce_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            flash_we_n_o <= 1'b1;
            flash_dq_o <= '0;
            flash_dq_oe_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            flash_addr_o <= addr_q;
            flash_ce_n_o <= !busy_q;
            flash_oe_n_o <= rd_oe_n;
            flash_we_n_o <= 1'b1;
            flash_dq_o <= '0;
            flash_dq_oe_o <= 1'b0;
            busy_o <= busy_q;
        end
    end
endmodule

// ---- test/fsp_flash_model.sv ----
// Behavioural flash device answering status reads
`timescale 1ns/1ps
module fsp_flash_model (
    input wire logic ce_n_i,
    input wire logic oe_n_i,
    input wire logic ld_i,
    input wire logic [1:0] kind_i,
    input wire logic [7:0] nrd_i,
    input wire logic tmo_i,
    input wire logic babt_i,
    input wire logic [7:0] data_i,
    output logic [15:0] dq_o
);
    logic [7:0] rem = 8'h0;
    logic t1 = 1'b0;
    logic t2 = 1'b0;
    logic [15:0] last = 16'h0;
    logic [7:0] st;
    wire drv = !ce_n_i && !oe_n_i;
    // ==========
    // Kind 0 program, 1 erase, 2 erase suspended
    assign st = (kind_i == 2'h0) ? {~data_i[7], t1, tmo_i, 3'h0, babt_i, 1'b0} :
        {kind_i[1], t1, tmo_i, 2'h0, t2, 2'h0};
    wire [15:0] word = (rem != 8'h0) ? {8'h0, st} : {8'h0, data_i};
    assign dq_o = drv ? word : ~last;
    always @* if (drv) last = word;
    always @(posedge oe_n_i or posedge ld_i) begin
        if (ld_i) begin
            rem <= nrd_i;
            t1 <= 1'b0;
            t2 <= 1'b0;
        end else if (!ce_n_i && rem != 8'h0) begin
            t1 <= t1 ^ (kind_i != 2'h2);
            t2 <= t2 ^ (kind_i != 2'h0);
            if (!tmo_i && !babt_i && kind_i != 2'h2) rem <= rem - 8'h1;
        end
    end
endmodule

// ---- test/fsp_poller_chk_assertions.sv ----
// Checker of the flash status poller ports
`timescale 1ns/1ps
module fsp_poller_chk #(
    parameter int AW = fsp_pkg::FSP_AW
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic [AW-1:0] flash_addr_o,
    input wire logic flash_ce_n_o,
    input wire logic flash_oe_n_o,
    input wire logic flash_dq_oe_o,
    input wire logic busy_o
);
    import fsp_pkg::*;
    logic [3:0] nrd_q;
    wire start = reg_wr_i && reg_addr_i == FSP_REG_CTRL && reg_wdata_i[FSP_CTRL_START];
    wire awr = reg_wr_i && reg_addr_i == FSP_REG_ADDR;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // ==========
    // Reads per session
    always_ff @(posedge clk_sys_i) begin
        if (flash_ce_n_o) begin
            nrd_q <= 4'h0;
        end else if ($fell(flash_oe_n_o) && nrd_q != 4'hf) begin
            nrd_q <= nrd_q + 4'h1;
        end
    end
    chk_two_reads: assert property ($rose(flash_ce_n_o) |-> nrd_q >= 4'h2)
        else $error("session ended with fewer than two reads");
    chk_start_busy: assert property (start && !busy_o |-> ##[1:3] (busy_o && !flash_ce_n_o))
        else $error("start did not open a session");
    chk_idle_ce: assert property (!busy_o ##1 !busy_o |-> flash_ce_n_o)
        else $error("chip enable low while idle");
    chk_oe_in_ce: assert property (!flash_oe_n_o |-> !flash_ce_n_o)
        else $error("output enable outside chip enable");
    chk_oe_low_len: assert property ($fell(flash_oe_n_o) |-> !flash_oe_n_o[*8] ##9 !flash_oe_n_o)
        else $error("read strobe too short");
    chk_oe_gap: assert property ($rose(flash_oe_n_o) |-> flash_oe_n_o[*4])
        else $error("no gap between reads");
    chk_addr_hold: assert property (!flash_ce_n_o && !$past(flash_ce_n_o) |-> $stable(flash_addr_o))
        else $error("address moved in session");
    chk_addr_src: assert property ($changed(flash_addr_o) |-> $past(awr) || $past(awr, 2))
        else $error("address changed without write");
    chk_no_drive: assert property (!flash_dq_oe_o)
        else $error("data bus driven");
endmodule
bind fsp_status_poller fsp_poller_chk #(.AW(AW)) fsp_poller_chk_inst (.clk_sys_i, .rst_n_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .flash_addr_o, .flash_ce_n_o, .flash_oe_n_o, .flash_dq_oe_o, .busy_o);

// ---- test/tb.sv ----
// Self-checking bench of the flash status poller
`timescale 1ns/1ps
`define CMP(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    import fsp_pkg::*;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [3:0] ra = 4'h0;
    logic [31:0] wd = 32'h0;
    logic wr = 1'b0, rd = 1'b0, rd_q = 1'b0, ld = 1'b0, tmo = 1'b0, babt = 1'b0;
    logic [1:0] kind = 2'h0;
    logic [7:0] nrd = 8'h1, dat = 8'h0;
    logic [31:0] seed = 32'h0000fd3c;
    logic [31:0] rdata, e_v, m_v;
    logic ce_n, oe_n, busy;
    logic [15:0] dq;
    logic [31:0] exp_q[$], msk_q[$];
    int n_mismatch = 0, n_tests = 0, cyc = 0;
    fsp_status_poller fsp_status_poller_inst (.clk_sys_i, .rst_n_i, .reg_addr_i(ra), .reg_wdata_i(wd),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .flash_addr_o(), .flash_ce_n_o(ce_n),
        .flash_oe_n_o(oe_n), .flash_we_n_o(), .flash_dq_i(dq), .flash_dq_o(), .flash_dq_oe_o(), .busy_o(busy));
    fsp_flash_model fsp_flash_model_inst (.ce_n_i(ce_n), .oe_n_i(oe_n), .ld_i(ld), .kind_i(kind), .nrd_i(nrd),
        .tmo_i(tmo), .babt_i(babt), .data_i(dat), .dq_o(dq));
    initial forever #4 clk_sys_i = ~clk_sys_i;
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task automatic end_sim();
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ==========
    // Result watcher and hang guard
    always @(posedge clk_sys_i) begin
        cyc++;
        rd_q <= rd;
        if (rd_q) begin
            e_v = exp_q.pop_front();
            m_v = msk_q.pop_front();
            `CMP(rdata & m_v, e_v)
        end
        if (cyc == 30000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        ra <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge clk_sys_i);
        ra <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
    endtask
    task automatic run(input logic [1:0] k, input logic md, input logic t, input logic b, input logic a,
        input logic [31:0] e, input logic [31:0] m);
        int i;
        logic [7:0] d;
        seed = xs(seed);
        d = k[0] ? 8'hff : seed[7:0];
        @(posedge clk_sys_i);
        kind <= k;
        tmo <= t;
        babt <= b;
        dat <= d;
        nrd <= {5'h0, seed[10:8]} + 8'h1;
        ld <= 1'b1;
        @(posedge clk_sys_i);
        ld <= 1'b0;
        wr_reg(FSP_REG_ADDR, {6'h0, seed[31:6]});
        wr_reg(FSP_REG_DATA, {24'h0, d});
        rd_reg(FSP_REG_ADDR, {6'h0, seed[31:6]}, 32'hffffffff);
        wr_reg(FSP_REG_CTRL, {30'h0, md, 1'b1});
        if (a) wr_reg(FSP_REG_CTRL, 32'h4);
        repeat (4) @(posedge clk_sys_i);
        for (i = 0; i < 5000 && busy !== 1'b0; i++) @(posedge clk_sys_i);
        rd_reg(FSP_REG_STAT, e, m);
        if (e[FSP_ST_DONE]) rd_reg(FSP_REG_DATA, {8'h0, d, 8'h0, d}, 32'h00ffffff);
    endtask
    initial begin
        int j;
        repeat (12) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd_reg(FSP_REG_STAT, 32'h0, 32'hffffffff);
        rd_reg(4'h2, 32'h0, 32'hffffffff);
        run(2'h0, FSP_MODE_TOGGLE, 1'b1, 1'b0, 1'b0, 32'h24, 32'h25);
        run(2'h0, FSP_MODE_TOGGLE, 1'b0, 1'b1, 1'b0, 32'h28, 32'h29);
        run(2'h2, FSP_MODE_TOGGLE, 1'b0, 1'b0, 1'b0, 32'h10, 32'h11);
        run(2'h1, FSP_MODE_TOGGLE, 1'b1, 1'b0, 1'b1, 32'h0, 32'h27);
        for (j = 0; j < 8; j++) run({1'b0, j[1]}, j[0], 1'b0, 1'b0, 1'b0, 32'h2, 32'h27);
        end_sim();
    end
endmodule
